// ### shared/fpx_pkg.sv
// fpx_pkg: constants and types of the floating-point exception unit.
// assumes one 25 MHz clock and an arithmetic datapath beside the unit.
package fpx_pkg;
   // address width of the instruction pointer
   localparam int ADDR_W = 20;
   localparam int FLAG_W = 6;
   // flag positions in the exception flag vector, precedence order
   localparam int FLG_IE = 0;
   localparam int FLG_DE = 1;
   localparam int FLG_ZE = 2;
   localparam int FLG_OE = 3;
   localparam int FLG_UE = 4;
   localparam int FLG_PE = 5;
   localparam logic [FLAG_W-1:0] FLAGS_RST = 6'h00;
   localparam logic [ADDR_W-1:0] ADDR_RST  = 20'h00000;
   // internal activity after reset release, in clocks
   localparam int INIT_CLOCKS = 25;
   localparam int INIT_CYCLES = INIT_CLOCKS;
   localparam logic [4:0] INIT_LAST = 5'(INIT_CYCLES - 1);

   typedef enum logic [1:0] {
      RND_NEAR = 2'b00,
      RND_DOWN = 2'b01,
      RND_UP   = 2'b10,
      RND_CHOP = 2'b11
   } fpx_rnd_e;

   typedef enum logic [3:0] {
      OP_ADD    = 4'h0,
      OP_MUL    = 4'h1,
      OP_DIV    = 4'h2,
      OP_SQRT   = 4'h3,
      OP_PREM   = 4'h4,
      OP_BCDST  = 4'h5,
      OP_INTST  = 4'h6,
      OP_CMP    = 4'h7,
      OP_LDEXT  = 4'h8,
      OP_LDSD   = 4'h9,
      OP_XTRACT = 4'hA,
      OP_TRANS  = 4'hB,
      OP_PTAN   = 4'hC,
      OP_SCALE  = 4'hD,
      OP_NOP    = 4'hE
   } fpx_op_e;

   typedef enum logic [2:0] {
      CLS_ZERO  = 3'h0,
      CLS_NORM  = 3'h1,
      CLS_DEN   = 3'h2,
      CLS_INF   = 3'h3,
      CLS_QNAN  = 3'h4,
      CLS_SNAN  = 3'h5,
      CLS_UNSUP = 3'h6
   } fpx_cls_e;

   typedef enum logic [3:0] {
      RES_DP      = 4'h0,
      RES_QNAN    = 4'h1,
      RES_QNAN2   = 4'h2,
      RES_INF     = 4'h3,
      RES_NINF_2  = 4'h4,
      RES_ZERO    = 4'h5,
      RES_MAXFIN  = 4'h6,
      RES_IND_INT = 4'h7,
      RES_IND_BCD = 4'h8,
      RES_DENORM  = 4'h9
   } fpx_res_e;
endpackage : fpx_pkg

// ### shared/fpx_cls_if.sv
// fpx_cls_if: operand facts in, pre-operation verdict out.
// assumes the main unit drives the facts from its latched request.
`timescale 1ns/1ns
interface fpx_cls_if;
   import fpx_pkg::*;
   fpx_op_e  op;
   fpx_cls_e a_cls;
   fpx_cls_e b_cls;
   logic     a_sign;
   logic     b_sign;
   logic     stack_err;
   logic     stack_over;
   logic     inv;
   logic     den;
   logic     zdiv;
   fpx_res_e kind;
   logic     sign;
   logic     under_ok;

   modport unit (output op, a_cls, b_cls, a_sign, b_sign, stack_err, stack_over,
                 input inv, den, zdiv, kind, sign, under_ok);
   modport judge (input op, a_cls, b_cls, a_sign, b_sign, stack_err, stack_over,
                  output inv, den, zdiv, kind, sign, under_ok);
endinterface : fpx_cls_if

// ### src/fpx_classify.sv
// fpx_classify: combinational pre-operation exception verdict.
// assumes operand classes are stable while the unit sits in its check state.
`timescale 1ns/1ns
module fpx_classify (
   fpx_cls_if.judge c
);
   import fpx_pkg::*;

   // operand facts
   wire two_op  = c.op inside {OP_ADD, OP_MUL, OP_DIV, OP_PREM, OP_CMP, OP_SCALE};
   wire a_zero  = c.a_cls == CLS_ZERO;
   wire b_zero  = two_op && c.b_cls == CLS_ZERO;
   wire a_inf   = c.a_cls == CLS_INF;
   wire b_inf   = two_op && c.b_cls == CLS_INF;
   wire a_fin   = c.a_cls inside {CLS_NORM, CLS_DEN};
   wire a_real  = a_fin || a_zero;
   wire any_sn  = c.a_cls == CLS_SNAN || (two_op && c.b_cls == CLS_SNAN);
   wire any_qn  = c.a_cls == CLS_QNAN || (two_op && c.b_cls == CLS_QNAN);
   wire any_un  = c.a_cls == CLS_UNSUP || (two_op && c.b_cls == CLS_UNSUP);
   wire any_den = c.a_cls == CLS_DEN || (two_op && c.b_cls == CLS_DEN);
   wire ldext   = c.op == OP_LDEXT;
   wire strict  = c.op inside {OP_CMP, OP_INTST, OP_BCDST};

   // invalid operation sources; extended load is not numeric
   wire inv_nan = !ldext && (any_sn || any_un || (strict && any_qn));
   wire inv_add = c.op == OP_ADD && a_inf && b_inf && (c.a_sign != c.b_sign);
   wire inv_mul = c.op == OP_MUL && ((a_zero && b_inf) || (a_inf && b_zero));
   wire inv_div = c.op == OP_DIV && ((a_zero && b_zero) || (a_inf && b_inf));
   wire inv_sqr = c.op == OP_SQRT && c.a_sign && (a_fin || a_inf);
   wire inv_scl = c.op == OP_SCALE && a_zero && b_inf;
   assign c.inv = c.stack_err || inv_nan || inv_add || inv_mul || inv_div || inv_sqr || inv_scl;

   // denormals are flagged, never judged invalid, except on extended load and NOP
   assign c.den = !ldext && c.op != OP_NOP && any_den;
   assign c.zdiv = (c.op == OP_DIV && b_zero && a_fin) ||
                   (c.op == OP_XTRACT && a_zero);
   assign c.under_ok = c.op inside {OP_ADD, OP_MUL, OP_DIV, OP_SQRT, OP_PREM,
                                    OP_BCDST, OP_TRANS, OP_SCALE};

   // masked default result chosen before any arithmetic happens
   wire scl_inf = c.op == OP_SCALE && b_inf && a_real;
   assign c.kind = (c.stack_err && c.stack_over && c.op == OP_PTAN) ? RES_QNAN2 :
                   (c.inv && c.op == OP_BCDST) ? RES_IND_BCD :
                   (c.inv && c.op == OP_INTST) ? RES_IND_INT :
                   c.inv ? RES_QNAN :
                   (c.zdiv && c.op == OP_XTRACT) ? RES_NINF_2 :
                   c.zdiv ? RES_INF :
                   scl_inf ? (c.b_sign ? RES_ZERO : RES_INF) :
                   any_qn ? RES_QNAN : RES_DP;
   assign c.sign = (c.zdiv && c.op == OP_XTRACT) ? 1'b1 :
                   (c.op == OP_DIV) ? (c.a_sign ^ c.b_sign) : c.a_sign;
endmodule : fpx_classify

// ### src/fpx_unit.sv
// fpx_unit: numeric exception detection, masked results and error report.
// assumes the datapath reports result facts with res_valid after dp_go was sent,
// and that the host samples error_n only on its next escape instruction.
`timescale 1ns/1ns
module fpx_unit (
   input  wire logic                         clk,
   input  wire logic                         reset,
   input  wire logic                         op_start,
   input  wire fpx_pkg::fpx_op_e             op_code,
   input  wire fpx_pkg::fpx_cls_e            a_cls,
   input  wire logic                         a_sign,
   input  wire fpx_pkg::fpx_cls_e            b_cls,
   input  wire logic                         b_sign,
   input  wire logic                         stack_err,
   input  wire logic                         stack_over,
   input  wire logic [fpx_pkg::FLAG_W-1:0]   exc_mask,
   input  wire fpx_pkg::fpx_rnd_e            rnd_mode,
   input  wire logic                         clear_req,
   input  wire logic                         fetch_valid,
   input  wire logic [fpx_pkg::ADDR_W-1:0]   fetch_addr,
   input  wire logic                         fetch_prefix,
   input  wire logic                         fetch_escape,
   input  wire logic                         res_valid,
   input  wire logic                         res_overflow,
   input  wire logic                         res_massive,
   input  wire logic                         res_tiny,
   input  wire logic                         res_lossy,
   input  wire logic                         res_inexact,
   input  wire logic                         res_sign,
   output logic                              busy,
   output logic                              error_n,
   output logic [fpx_pkg::FLAG_W-1:0]        exc_flags,
   output logic                              stack_fault_flag,
   output logic                              error_summary_bit,
   output logic [fpx_pkg::ADDR_W-1:0]        fault_addr,
   output logic                              norm_req,
   output logic                              dp_go,
   output logic                              result_write,
   output logic                              result_abort,
   output fpx_pkg::fpx_res_e                 result_kind,
   output logic                              result_sign
);
   import fpx_pkg::*;

   // control states
   typedef enum logic [2:0] {
      ST_INIT   = 3'b000,
      ST_IDLE   = 3'b001,
      ST_CHECK  = 3'b010,
      ST_DP     = 3'b011,
      ST_COMMIT = 3'b100,
      ST_REPORT = 3'b101,
      ST_CLEAR  = 3'b110
   } fpx_state_e;

   // masked overflow result by rounding direction and sign
   function automatic fpx_res_e ovf_kind(input fpx_rnd_e rm, input logic sgn);
      fpx_res_e k;
      k = RES_INF;

      unique case (rm)
         RND_NEAR: k = RES_INF;
         RND_CHOP: k = RES_MAXFIN;
         RND_DOWN: k = sgn ? RES_INF : RES_MAXFIN;
         RND_UP:   k = sgn ? RES_MAXFIN : RES_INF;
      endcase
      return k;
   endfunction : ovf_kind

   // control, request
   fpx_state_e              state_q, state_d;
   logic [4:0]              init_cnt_q;
   fpx_op_e                 op_q;
   fpx_cls_e                a_cls_q, b_cls_q;
   logic                    a_sign_q, b_sign_q, stk_err_q, stk_over_q;

   // staged outcome
   logic [FLAG_W-1:0]       pend_q, pend_d;
   logic                    sf_q, sf_d;
   fpx_res_e                kind_q, kind_d;
   logic                    sign_q, sign_d, abort_q, abort_d;

   // address tracking
   logic                    pfx_pend_q;
   logic [ADDR_W-1:0]       pfx_addr_q, esc_addr_q, ip_q;

   fpx_cls_if cls ();

   // classifier sees the request as latched at start
   assign cls.op         = op_q;
   assign cls.a_cls      = a_cls_q;
   assign cls.b_cls      = b_cls_q;
   assign cls.a_sign     = a_sign_q;
   assign cls.b_sign     = b_sign_q;

   assign cls.stack_err  = stk_err_q;
   assign cls.stack_over = stk_over_q;

   // judge latched operands
   fpx_classify u_classify (
      .c (cls.judge)
   );

   // pre-operation precedence: invalid, then denormal, then zero divide
   wire pre_ie   = cls.inv;
   wire pre_de   = cls.den && !pre_ie;
   wire de_stop  = pre_de && !exc_mask[FLG_DE];
   wire pre_ze   = cls.zdiv && !pre_ie && !de_stop;
   wire pre_stop = (pre_ie && !exc_mask[FLG_IE]) || de_stop ||
                   (pre_ze && !exc_mask[FLG_ZE]);

   wire go_dp    = !pre_stop && !pre_ie && !pre_ze && cls.kind == RES_DP;
   wire do_norm  = pre_de && exc_mask[FLG_DE];

   // post-operation flags from the datapath result facts
   wire post_oe  = res_overflow;
   wire tiny_ok  = cls.under_ok && res_tiny;
   wire post_ue  = tiny_ok && (!exc_mask[FLG_UE] || res_lossy);
   wire post_pe  = res_inexact || (post_oe && exc_mask[FLG_OE]);

   // above the pre-op flags
   wire [FLAG_W-1:0] post_flags = {post_pe, post_ue, post_oe, 3'b000};
   wire [FLAG_W-1:0] pre_flags  = {3'b000, pre_ze, pre_de, pre_ie};

   // result chosen on over/underflow
   wire fpx_res_e ovf_res = exc_mask[FLG_OE] ? ovf_kind(rnd_mode, res_sign) :
                            (res_massive ? RES_INF : RES_DP);

   wire fpx_res_e unf_res = exc_mask[FLG_UE] ? RES_DENORM :
                            (res_massive ? RES_ZERO : RES_DP);

   wire fpx_res_e post_res = post_oe ? ovf_res : (tiny_ok ? unf_res : RES_DP);

   // any pending flag whose mask is clear makes the commit a reported error
   wire unmasked_hit = |(pend_q & ~exc_mask);

   // next state and staged results
   always_comb begin
      state_d = state_q;
      pend_d  = pend_q;
      sf_d    = sf_q;
      kind_d  = kind_q;
      sign_d  = sign_q;
      abort_d = abort_q;

      unique case (state_q)
         ST_INIT: begin
            if (init_cnt_q == INIT_LAST) state_d = ST_IDLE;
         end

         ST_IDLE: begin
            if (clear_req) begin
               state_d = ST_CLEAR;
            end else if (op_start) begin
               state_d = ST_CHECK;
               pend_d  = FLAGS_RST;
               sf_d    = 1'b0;
               abort_d = 1'b0;
            end
         end

         ST_CHECK: begin
            pend_d  = pre_flags;
            sf_d    = stk_err_q;
            kind_d  = cls.kind;
            sign_d  = cls.sign;
            abort_d = pre_stop;
            state_d = go_dp ? ST_DP : ST_COMMIT;
         end

         ST_DP: begin
            if (res_valid) begin
               pend_d  = pend_q | post_flags;
               kind_d  = post_res;
               sign_d  = res_sign;
               state_d = ST_COMMIT;
            end
         end

         // commit or clear, then report, then idle
         ST_COMMIT: state_d = ST_REPORT;
         ST_REPORT: state_d = ST_IDLE;
         ST_CLEAR:  state_d = ST_REPORT;
         default:   state_d = ST_IDLE;
      endcase
   end

   // control state and init counter
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state_q    <= ST_INIT;
         init_cnt_q <= 5'h00;
      end else begin
         state_q    <= state_d;
         init_cnt_q <= (state_q == ST_INIT) ? init_cnt_q + 5'h01 : 5'h00;
      end
   end

   // latch the request at start so operands may change behind us
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         op_q       <= OP_NOP;
         a_cls_q    <= CLS_ZERO;
         b_cls_q    <= CLS_ZERO;
         a_sign_q   <= 1'b0;
         b_sign_q   <= 1'b0;
         stk_err_q  <= 1'b0;
         stk_over_q <= 1'b0;
      end else if (state_q == ST_IDLE && op_start && !clear_req) begin
         op_q       <= op_code;
         a_cls_q    <= a_cls;
         b_cls_q    <= b_cls;
         a_sign_q   <= a_sign;
         b_sign_q   <= b_sign;
         stk_err_q  <= stack_err;
         stk_over_q <= stack_over;
      end
   end

   // staged flags and result for the commit
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pend_q  <= FLAGS_RST;
         sf_q    <= 1'b0;
         kind_q  <= RES_DP;
         sign_q  <= 1'b0;
         abort_q <= 1'b0;
      end else begin
         pend_q  <= pend_d;
         sf_q    <= sf_d;
         kind_q  <= kind_d;
         sign_q  <= sign_d;
         abort_q <= abort_d;
      end
   end

   // prefix tracking: the first prefix byte marks the instruction start
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pfx_pend_q <= 1'b0;
         pfx_addr_q <= ADDR_RST;
         esc_addr_q <= ADDR_RST;
      end else if (fetch_valid) begin
         if (fetch_prefix) begin
            if (!pfx_pend_q) pfx_addr_q <= fetch_addr;
            pfx_pend_q <= 1'b1;
         end else begin
            // else own address
            if (fetch_escape) esc_addr_q <= pfx_pend_q ? pfx_addr_q : fetch_addr;
            pfx_pend_q <= 1'b0;
         end
      end
   end

   // instruction pointer of the op in flight, kept as fault address
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ip_q       <= ADDR_RST;
         fault_addr <= ADDR_RST;
      end else begin
         if (state_q == ST_IDLE && op_start && !clear_req) ip_q <= esc_addr_q;
         // clean ops keep it
         if (state_q == ST_COMMIT && |pend_q) fault_addr <= ip_q;
      end
   end

   // sticky flags; clear only runs in its own state, so no set is lost
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         exc_flags         <= FLAGS_RST;
         stack_fault_flag  <= 1'b0;
         error_summary_bit <= 1'b0;
      end else if (state_q == ST_CLEAR) begin
         exc_flags         <= FLAGS_RST;
         stack_fault_flag  <= 1'b0;
         error_summary_bit <= 1'b0;
      end else if (state_q == ST_COMMIT) begin
         exc_flags         <= exc_flags | pend_q;
         stack_fault_flag  <= stack_fault_flag | sf_q;
         error_summary_bit <= error_summary_bit | unmasked_hit;
      end
   end

   // busy high through reset and every non-idle state
   always_ff @(posedge clk or posedge reset) begin
      if (reset) busy <= 1'b1;
      else       busy <= state_d != ST_IDLE;
   end

   // error pin: dedicated active-low line, moved only inside busy
   always_ff @(posedge clk or posedge reset) begin
      if (reset) error_n <= 1'b1;
      else if (busy && state_q == ST_REPORT) error_n <= !error_summary_bit;
   end

   // one-cycle strobes toward the datapath and register stack
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         norm_req     <= 1'b0;
         dp_go        <= 1'b0;
         result_write <= 1'b0;
         result_abort <= 1'b0;
         result_kind  <= RES_DP;
         result_sign  <= 1'b0;
      end else begin
         norm_req     <= state_q == ST_CHECK && do_norm && !pre_stop;
         dp_go        <= state_q == ST_CHECK && go_dp;
         result_write <= state_q == ST_COMMIT && !abort_q;
         result_abort <= state_q == ST_COMMIT && abort_q;

         // held to next commit
         if (state_q == ST_COMMIT) begin
            result_kind <= kind_q;
            result_sign <= sign_q;
         end
      end
   end
endmodule : fpx_unit

// ### bench/fpx_properties.sv
// fpx_properties: port-level timing checks of the exception unit.
// assumes it is bound to fpx_unit, one clock, async active-high reset.
`timescale 1ns/1ns
module fpx_properties
   import fpx_pkg::*;
(
   input wire logic              clk,
   input wire logic              reset,
   input wire logic              busy,
   input wire logic              error_n,
   input wire logic [FLAG_W-1:0] exc_flags,
   input wire logic [FLAG_W-1:0] exc_mask,
   input wire logic              stack_fault_flag,
   input wire logic              error_summary_bit,
   input wire logic [ADDR_W-1:0] fault_addr,
   input wire logic              norm_req,
   input wire logic              result_write,
   input wire logic              result_abort
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   // end of any transfer and the unmasked part of the flags
   wire logic              done = result_write | result_abort;
   wire logic [FLAG_W-1:0] live = exc_flags & ~exc_mask;
   // completion then idle: the report step has finished by then
   sequence s_done;
      done ##1 !busy;
   endsequence
   a_err_follow: assert property (s_done |-> error_n == !error_summary_bit)
      else $error("error line differs from summary after report");
   a_err_busy_only: assert property (!$stable(error_n) |-> $past(busy))
      else $error("error line moved while not busy");
   a_sum_drives_err: assert property ($rose(error_summary_bit) |-> ##[0:2] !error_n)
      else $error("summary set but error line stayed high");
   a_sum_has_cause: assert property ($rose(error_summary_bit) |-> live != 6'h00)
      else $error("summary set with no unmasked flag");
   a_abort_flagged: assert property (result_abort |-> live != 6'h00 && error_summary_bit)
      else $error("abort without unmasked flag and summary");
   a_stack_is_inv: assert property ($rose(stack_fault_flag) |-> exc_flags[FLG_IE])
      else $error("stack fault without invalid flag");
   a_norm_masked: assert property (norm_req |-> exc_mask[FLG_DE])
      else $error("normalise request with denormal unmasked");
   a_addr_commit: assert property (!$stable(fault_addr) |-> done)
      else $error("fault address moved outside commit");
   // init activity keeps busy up well past release
   a_init_busy: assert property ($fell(reset) |-> busy [*8])
      else $error("busy dropped early after reset");
endmodule : fpx_properties

bind fpx_unit fpx_properties u_props (.clk, .reset, .busy, .error_n, .exc_flags, .exc_mask, .stack_fault_flag,
   .error_summary_bit, .fault_addr, .norm_req, .result_write, .result_abort);

// ### bench/fpx_host_model.sv
// fpx_host_model: datapath answer plus host that samples the error line.
// assumes facts are set before dp_go; escape marks a host escape opcode.
`timescale 1ns/1ns
module fpx_host_model (
   input  wire logic       clk,
   input  wire logic       dp_go,
   input  wire logic [3:0] lat,
   input  wire logic [5:0] facts,
   input  wire logic       escape,
   input  wire logic       error_n,
   output logic            res_valid,
   output logic [5:0]      res_f,
   output int              traps,
   output logic [7:0]      trap_vec
);
   int cnt = -1;
   initial begin
      res_valid = 1'b0;
      res_f = 6'h00;
      traps = 0;
      trap_vec = 8'h00;
   end
   // answer lat+1 clocks after dp_go is seen; facts scramble outside the valid cycle
   always @(negedge clk) begin
      res_valid <= 1'b0;
      res_f <= ~res_f;
      if (dp_go) cnt <= lat;
      else if (cnt > 0) cnt <= cnt - 1;
      if (cnt == 0) begin
         res_valid <= 1'b1;
         res_f <= facts;
         cnt <= -1;
      end
   end
   // error line looked at only on an escape, then vector 16
   always @(posedge clk) begin
      if (escape && !error_n) begin
         traps <= traps + 1;
         trap_vec <= 8'h10;
      end
   end
endmodule : fpx_host_model

// ### bench/fpx_unit_test.sv
// fpx_unit_test: scenario bench for the exception unit.
// assumes the unit, host model and bound checker alongside.
`timescale 1ns/1ns
module fpx_unit_test;
   import fpx_pkg::*;
   logic clk = 0, reset = 1, op_start = 0, a_sign = 0, b_sign = 0, stack_err = 0, stack_over = 0;
   logic clear_req = 0, fetch_valid = 0, fetch_prefix = 0, fetch_escape = 0, esc_host = 0;
   logic busy, error_n, stack_fault_flag, error_summary_bit, norm_req, dp_go, result_write, result_abort;
   logic result_sign, res_valid, s, ab, nrm, sf;
   logic [5:0]  exc_mask = 6'h3F, facts = 6'h00, exc_flags, res_f, f;
   logic [19:0] fetch_addr = 20'h00000, fault_addr;
   logic [3:0]  lat = 4'h0;
   logic [7:0]  trap_vec;
   fpx_op_e     op_code = OP_NOP;
   fpx_cls_e    a_cls = CLS_NORM, b_cls = CLS_NORM;
   fpx_rnd_e    rnd_mode = RND_NEAR;
   fpx_res_e    result_kind, k;
   int          fail_count = 0, checks_done = 0, cyc = 0, traps;

   fpx_unit DUT (.clk, .reset, .op_start, .op_code, .a_cls, .a_sign, .b_cls, .b_sign, .stack_err,
      .stack_over, .exc_mask, .rnd_mode, .clear_req, .fetch_valid, .fetch_addr, .fetch_prefix,
      .fetch_escape, .res_valid, .res_overflow(res_f[5]), .res_massive(res_f[4]), .res_tiny(res_f[3]),
      .res_lossy(res_f[2]), .res_inexact(res_f[1]), .res_sign(res_f[0]), .busy, .error_n, .exc_flags,
      .stack_fault_flag, .error_summary_bit, .fault_addr, .norm_req, .dp_go, .result_write,
      .result_abort, .result_kind, .result_sign);
   // error line wired straight to the host, no controller between
   fpx_host_model u_host (.clk, .dp_go, .lat, .facts, .escape(esc_host), .error_n, .res_valid,
      .res_f, .traps, .trap_vec);

   initial begin
      forever #20 clk = ~clk;
   end
   // hang guard, far above the run length
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         end_sim();
      end
   end

   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : end_sim

   task automatic chk(input string n, input logic [19:0] e, input logic [19:0] g);
      checks_done++;
      if (g !== e) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   // one request, then wait for its result pulse and capture it
   task automatic run(input fpx_op_e o, input fpx_cls_e a, input fpx_cls_e b, input logic [1:0] st);
      int i;
      op_code = o;
      a_cls = a;
      b_cls = b;
      {stack_err, stack_over} = st;
      op_start = 1'b1;
      @(negedge clk);
      op_start = 1'b0;
      nrm = 1'b0;
      for (i = 0; i < 40 && (result_write | result_abort) !== 1'b1; i++) begin
         @(negedge clk);
         nrm |= norm_req;
      end
      chk("done", 1, result_write | result_abort);
      k = result_kind;
      {s, f, ab, sf} = {result_sign, exc_flags, result_abort, stack_fault_flag};
      @(negedge clk);
   endtask : run

   task automatic clr();
      clear_req = 1'b1;
      @(negedge clk);
      clear_req = 1'b0;
      repeat (3) @(negedge clk);
      chk("clear", 20'h00001, {exc_flags, stack_fault_flag, error_summary_bit, error_n});
   endtask : clr

   // one case under the current exc_mask: flags, stack fault and, unless ek is F, kind and sign
   task automatic ex(input fpx_op_e o, input fpx_cls_e a, input fpx_cls_e b, input logic [1:0] st,
                     input logic [5:0] ef, input logic [3:0] ek, input logic es);
      run(o, a, b, st);
      chk("flags", ef, f);
      chk("stack_fault", st[1], sf);
      if (ek != 4'hF) chk("kind", {ek, es}, {k, s});
      clr();
   endtask : ex

   task automatic fb(input logic [19:0] ad, input logic p, input logic e);
      {fetch_valid, fetch_addr, fetch_prefix, fetch_escape} = {1'b1, ad, p, e};
      @(negedge clk);
   endtask : fb

   task automatic t_add();
      lat = 4'h5;
      run(OP_ADD, CLS_NORM, CLS_NORM, 2'b00);
      chk("plain", {RES_DP, 6'h00, 2'b01}, {k, f, ab, error_n});
      run(OP_ADD, CLS_DEN, CLS_NORM, 2'b00);
      chk("normalise", {RES_DP, 6'h02, 2'b10}, {k, f, nrm, ab});
      clr();
      lat = 4'h0;
   endtask : t_add

   task automatic t_report();
      exc_mask = 6'h3B;
      fb(20'h1234A, 1, 0);
      fb(20'h1234B, 1, 0);
      fb(20'h1234C, 0, 1);
      fetch_valid = 1'b0;
      run(OP_DIV, CLS_NORM, CLS_ZERO, 2'b00);
      chk("abort", {6'h04, 3'b110}, {f, ab, error_summary_bit, error_n});
      chk("fault_addr", 20'h1234A, fault_addr);
      chk("traps", 0, traps);
      esc_host = 1'b1;
      @(negedge clk);
      esc_host = 1'b0;
      @(negedge clk);
      chk("vector", {8'h01, 8'h10}, {traps[7:0], trap_vec});
      clr();
      fb(20'h00300, 1, 0);
      fb(20'h00301, 0, 0);
      fb(20'h00302, 0, 1);
      fetch_valid = 1'b0;
      run(OP_DIV, CLS_NORM, CLS_ZERO, 2'b00);
      chk("fault_addr", 20'h00302, fault_addr);
      clr();
      exc_mask = 6'h3D;
      ex(OP_DIV, CLS_DEN, CLS_ZERO, 2'b00, 6'h02, 4'hF, 0);
      exc_mask = 6'h3F;
   endtask : t_report

   task automatic t_classes();
      ex(OP_SQRT, CLS_DEN, CLS_NORM, 2'b00, 6'h02, 4'hF, 0);
      ex(OP_DIV, CLS_NORM, CLS_DEN, 2'b00, 6'h02, 4'hF, 0);
      ex(OP_XTRACT, CLS_DEN, CLS_NORM, 2'b00, 6'h02, 4'hF, 0);
      ex(OP_TRANS, CLS_DEN, CLS_NORM, 2'b00, 6'h02, 4'hF, 0);
      ex(OP_XTRACT, CLS_ZERO, CLS_NORM, 2'b00, 6'h04, RES_NINF_2, 1);
      ex(OP_LDEXT, CLS_DEN, CLS_NORM, 2'b00, 6'h00, 4'hF, 0);
      ex(OP_LDSD, CLS_DEN, CLS_NORM, 2'b00, 6'h02, 4'hF, 0);
      ex(OP_LDSD, CLS_SNAN, CLS_NORM, 2'b00, 6'h01, 4'hF, 0);
      ex(OP_ADD, CLS_QNAN, CLS_NORM, 2'b00, 6'h00, RES_QNAN, 0);
      ex(OP_ADD, CLS_SNAN, CLS_NORM, 2'b00, 6'h01, RES_QNAN, 0);
      ex(OP_ADD, CLS_UNSUP, CLS_NORM, 2'b00, 6'h01, RES_QNAN, 0);
      ex(OP_CMP, CLS_QNAN, CLS_NORM, 2'b00, 6'h01, 4'hF, 0);
      ex(OP_INTST, CLS_QNAN, CLS_NORM, 2'b00, 6'h01, RES_IND_INT, 0);
      ex(OP_BCDST, CLS_QNAN, CLS_NORM, 2'b00, 6'h01, RES_IND_BCD, 0);
      ex(OP_ADD, CLS_SNAN, CLS_DEN, 2'b00, 6'h01, 4'hF, 0);
      ex(OP_ADD, CLS_NORM, CLS_NORM, 2'b10, 6'h01, 4'hF, 0);
      ex(OP_PTAN, CLS_NORM, CLS_NORM, 2'b11, 6'h01, RES_QNAN2, 0);
      ex(OP_SCALE, CLS_ZERO, CLS_INF, 2'b00, 6'h01, 4'hF, 0);
      {a_sign, b_sign} = 2'b11;
      ex(OP_SCALE, CLS_NORM, CLS_INF, 2'b00, 6'h00, RES_ZERO, 1);
      b_sign = 1'b0;
      ex(OP_SCALE, CLS_NORM, CLS_INF, 2'b00, 6'h00, RES_INF, 1);
      a_sign = 1'b0;
   endtask : t_classes

   // masked overflow under every rounding mode and both signs
   task automatic t_round();
      logic mx;
      for (int i = 0; i < 8; i++) begin
         rnd_mode = fpx_rnd_e'(i[1:0]);
         facts = {5'h10, i[2]};
         mx = rnd_mode == RND_CHOP || (rnd_mode == RND_DOWN && !i[2]) || (rnd_mode == RND_UP && i[2]);
         ex(OP_ADD, CLS_NORM, CLS_NORM, 2'b00, 6'h28, mx ? RES_MAXFIN : RES_INF, i[2]);
      end
      rnd_mode = RND_NEAR;
   endtask : t_round

   task automatic t_under();
      fpx_op_e uo[4] = '{OP_ADD, OP_SQRT, OP_BCDST, OP_PREM};
      for (int i = 0; i < 8; i++) begin
         facts = {3'b001, i[2], i[2], 1'b0};
         run(uo[i[1:0]], CLS_NORM, CLS_NORM, 2'b00);
         chk("underflow", i[2], f[FLG_UE]);
         if (i[1:0] == 2'b00) chk("denorm", RES_DENORM, k);
         clr();
      end
   endtask : t_under

   task automatic t_massive();
      exc_mask = 6'h27;
      facts = 6'h31;
      run(OP_MUL, CLS_NORM, CLS_NORM, 2'b00);
      chk("massive_over", {RES_INF, 3'b110}, {k, s, f[FLG_OE], error_n});
      clr();
      facts = 6'h19;
      run(OP_MUL, CLS_NORM, CLS_NORM, 2'b00);
      chk("massive_under", {RES_ZERO, 3'b110}, {k, s, f[FLG_UE], error_n});
      clr();
      {exc_mask, facts} = {6'h3F, 6'h00};
   endtask : t_massive

   initial begin
      int n;
      repeat (16) @(negedge clk);
      chk("reset_pins", 2'b11, {busy, error_n});
      reset = 1'b0;
      for (n = 0; n < 40 && busy !== 1'b0; n++) @(negedge clk);
      chk("init_clocks", 25, n);
      t_add();
      t_report();
      t_classes();
      t_round();
      t_under();
      t_massive();
      end_sim();
   end
endmodule : fpx_unit_test
